/* File: nbwc_cfg.svh */
// constants for the nonvolatile byte write controller
`ifndef NBWC_CFG_SVH
`define NBWC_CFG_SVH
`define NBWC_CTRL_ADDR     12'hFCE
`define NBWC_ARRAY_BASE    12'h400
`define NBWC_CTRL_RESET    8'h00
`define NBWC_BIT_GATE      7
`define NBWC_BIT_SEL_HI    6
`define NBWC_BIT_SEL_LO    4
`define NBWC_BIT_PERMIT    3
`define NBWC_BIT_BUSY      2
`define NBWC_CLK_MHZ       50
`define NBWC_GATE_US       15
`define NBWC_GATE_CYCLES   (`NBWC_GATE_US * `NBWC_CLK_MHZ)
`define NBWC_TIME_MULT     18
`define NBWC_EXP_MAX       13
`define NBWC_SEL_LAST      3'h5
`define NBWC_UNDEF_BYTE    8'hFF
`endif

/* File: nbwc_pkg.sv */
// types for the nonvolatile byte write controller
package nbwc_pkg;
	typedef enum logic [1:0] {NBWC_IDLE, NBWC_ERASE, NBWC_PROG} nbwc_state_e;
	typedef logic [7:0] nbwc_byte_t;
endpackage : nbwc_pkg

/* File: nbwc_timer.sv */
// write duration down counter for the nonvolatile byte write controller
`timescale 1ns/100ps
`include "nbwc_cfg.svh"
module nbwc_timer (
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset_n,
	// control
	input  wire logic        i_start,
	input  wire logic        i_abort,
	input  wire logic [2:0]  i_sel,
	// status
	output logic             o_done,
	output logic [17:0]      o_count
);
	logic [17:0] count_q, count_d;
	logic        done_q, done_d;
	logic [17:0] load_v;

	// duration is 18 shl (13 - code); prohibited codes fall back to shortest
	always_comb begin
		load_v = 18'h00000;
		if (i_sel <= `NBWC_SEL_LAST) begin
			load_v = 18'(`NBWC_TIME_MULT) << (5'(`NBWC_EXP_MAX) - {2'h0, i_sel});
		end else begin
			load_v = 18'(`NBWC_TIME_MULT) << 8;
		end
	end

	// count down, pulse done on the last counted cycle
	// done is flagged one edge early so the owner drops busy after exactly the loaded count
	always_comb begin
		count_d = count_q;
		done_d  = 1'b0;
		if (i_abort) begin
			count_d = 18'h00000;
		end else if (i_start) begin
			count_d = load_v;
		end else if (count_q != 18'h00000) begin
			count_d = count_q - 18'h00001;
			done_d  = (count_q == 18'h00002);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			count_q <= 18'h00000;
			done_q  <= 1'b0;
		end else begin
			count_q <= count_d;
			done_q  <= done_d;
		end
	end

	assign o_done  = done_q;
	assign o_count = count_q;
endmodule : nbwc_timer

/* File: nbwc_ctrl.sv */
// top of the nonvolatile byte write controller: control register, array, sequencing
`timescale 1ns/100ps
`include "nbwc_cfg.svh"
module nbwc_ctrl (
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset_n,
	// cpu data memory access, byte wide
	input  wire logic [11:0] i_addr,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [7:0]  i_wdata,
	output logic [7:0]       o_rdata,
	// power modes
	input  wire logic        i_stop_mode,
	input  wire logic        i_halt_mode,
	// write done request and its enable
	input  wire logic        i_irq_enable,
	input  wire logic        i_irq_ack,
	output logic             o_nvm_write_done_irq,
	output logic             o_write_done_request_flag,
	// status mirrors
	output logic             o_nvm_write_busy,
	output logic             o_read_ready
);
	// control fields
	logic                    gate_q, gate_d;        // nvm_read_gate
	logic [2:0]              sel_q, sel_d;          // write_time_select
	logic                    permit_q, permit_d;    // nvm_write_permit
	nbwc_pkg::nbwc_state_e   state_q, state_d;
	logic [3:0]              waddr_q, waddr_d;      // latched target index
	nbwc_pkg::nbwc_byte_t    wdata_q, wdata_d;      // latched target byte
	logic                    req_q, req_d;          // write_done_request_flag
	logic                    irq_q, irq_d;
	logic [9:0]              gcnt_q, gcnt_d;        // read gate settle counter
	nbwc_pkg::nbwc_byte_t    rdata_q, rdata_d;
	logic                    busy_q, busy_d;        // nvm_write_busy, registered for the pin
	logic                    ready_q, ready_d;      // gate settled, registered for the pin
	nbwc_pkg::nbwc_byte_t    mem_q [16];
	logic                    busy_v;
	logic                    hit_ctrl, hit_array, start_v, abort_v, t_done;
	logic [17:0]             t_count;

	assign busy_v    = (state_q != nbwc_pkg::NBWC_IDLE);
	assign hit_ctrl  = (i_addr == `NBWC_CTRL_ADDR);
	assign hit_array = (i_addr[11:4] == 8'(`NBWC_ARRAY_BASE >> 4));
	// only an idle, permitted array write starts a cycle; array writes while busy vanish
	assign start_v   = i_wr && hit_array && permit_q && !busy_v;
	// permit cleared or stop mode kills the write; halt mode is not looked at
	assign abort_v   = busy_v && (!permit_q || i_stop_mode);

	nbwc_timer u_timer (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_start   (start_v),
		.i_abort   (abort_v),
		.i_sel     (sel_q),
		.o_done    (t_done),
		.o_count   (t_count)
	);

	// control register writes load the whole byte at once
	always_comb begin
		gate_d   = gate_q;
		sel_d    = sel_q;
		permit_d = permit_q;
		if (i_wr && hit_ctrl) begin
			gate_d   = i_wdata[`NBWC_BIT_GATE];
			sel_d    = i_wdata[`NBWC_BIT_SEL_HI:`NBWC_BIT_SEL_LO];
			permit_d = i_wdata[`NBWC_BIT_PERMIT];
		end
	end

	// write sequencer: erase until the count drops below 0x480, then program, timer owns duration
	always_comb begin
		state_d = state_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		case (state_q)
			nbwc_pkg::NBWC_IDLE: begin
				if (start_v) begin
					state_d = nbwc_pkg::NBWC_ERASE;
					waddr_d = i_addr[3:0];
					wdata_d = i_wdata;
				end
			end
			nbwc_pkg::NBWC_ERASE: begin
				if (abort_v || t_done) begin
					state_d = nbwc_pkg::NBWC_IDLE;
				end else if (t_count[17:1] == 17'h00000) begin
					state_d = nbwc_pkg::NBWC_PROG;
				end else if (t_count < 18'h00480) begin
					state_d = nbwc_pkg::NBWC_PROG;
				end
			end
			nbwc_pkg::NBWC_PROG: begin
				if (abort_v || t_done) begin
					state_d = nbwc_pkg::NBWC_IDLE;
				end
			end
			default: begin
				state_d = nbwc_pkg::NBWC_IDLE;
			end
		endcase
		// busy pin follows the next state so it lines up with state_q
		busy_d = (state_d != nbwc_pkg::NBWC_IDLE);
	end

	// array cells: each cell updates only on a finished or aborted write
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_cell
			nbwc_pkg::nbwc_byte_t cell_d;
			always_comb begin
				cell_d = mem_q[gi];
				if (busy_v && waddr_q == 4'(gi)) begin
					if (i_stop_mode) begin
						cell_d = `NBWC_UNDEF_BYTE;
					end else if (!permit_q) begin
						cell_d = 8'h00;
					end else if (t_done) begin
						cell_d = wdata_q;
					end
				end
			end
			always_ff @(posedge i_ref_clk) begin
				mem_q[gi] <= cell_d;
			end
		end
	endgenerate

	// read gate settle counter and read data
	always_comb begin
		gcnt_d = gcnt_q;
		if (!gate_q) begin
			gcnt_d = 10'h000;
		end else if (gcnt_q != 10'(`NBWC_GATE_CYCLES)) begin
			gcnt_d = gcnt_q + 10'h001;
		end
		// ready pin built from next values so it matches the read path timing
		ready_d = gate_d && (gcnt_d == 10'(`NBWC_GATE_CYCLES));
		rdata_d = rdata_q;
		if (i_rd && hit_ctrl) begin
			rdata_d = {gate_q, sel_q, permit_q, busy_v, 2'h0};
		end else if (i_rd && hit_array) begin
			if (busy_v) begin
				rdata_d = `NBWC_UNDEF_BYTE;
			end else if (gate_q && gcnt_q == 10'(`NBWC_GATE_CYCLES)) begin
				rdata_d = mem_q[i_addr[3:0]];
			end else begin
				rdata_d = 8'h00;
			end
		end else if (i_rd) begin
			rdata_d = 8'h00;
		end
	end

	// done request: sticky until ack, set beats ack
	always_comb begin
		req_d = req_q;
		if (i_irq_ack) begin
			req_d = 1'b0;
		end
		if (t_done && !abort_v) begin
			req_d = 1'b1;
		end
		irq_d = req_d && i_irq_enable;
	end

	// register everything; reset clears the control byte
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			gate_q   <= 1'b0;
			sel_q    <= 3'h0;
			permit_q <= 1'b0;
			state_q  <= nbwc_pkg::NBWC_IDLE;
			waddr_q  <= 4'h0;
			wdata_q  <= 8'h00;
			req_q    <= 1'b0;
			irq_q    <= 1'b0;
			gcnt_q   <= 10'h000;
			rdata_q  <= 8'h00;
			busy_q   <= 1'b0;
			ready_q  <= 1'b0;
		end else begin
			gate_q   <= gate_d;
			sel_q    <= sel_d;
			permit_q <= permit_d;
			state_q  <= state_d;
			waddr_q  <= waddr_d;
			wdata_q  <= wdata_d;
			req_q    <= req_d;
			irq_q    <= irq_d;
			gcnt_q   <= gcnt_d;
			rdata_q  <= rdata_d;
			busy_q   <= busy_d;
			ready_q  <= ready_d;
		end
	end

	assign o_rdata                   = rdata_q;
	assign o_write_done_request_flag = req_q;
	assign o_nvm_write_done_irq      = irq_q;
	assign o_nvm_write_busy          = busy_q;
	assign o_read_ready              = ready_q;

	// checks
	busy_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		start_v |=> o_nvm_write_busy) else $error("busy not set at start");
	ignore_busy_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(busy_v && i_wr && hit_array) |=> $stable(waddr_q) && $stable(wdata_q)) else $error("latch moved");
	no_permit_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(!busy_v && !permit_q) |=> !busy_v) else $error("write without permit");
	done_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(t_done && !abort_v) |=> !busy_v && req_q) else $error("done not ending write");
	abort_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(busy_v && !permit_q && !i_stop_mode) |=> mem_q[$past(waddr_q)] == 8'h00) else $error("abort not zero");
	gate_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!gate_q |=> !o_read_ready) else $error("ready without gate");
	shortest_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(start_v && sel_q == 3'h5) |=> t_count == 18'h01200) else $error("duration wrong");
	reset_clr_a: assert property (@(posedge i_ref_clk)
		!i_reset_n |=> !gate_q && sel_q == 3'h0 && !permit_q) else $error("reset not cleared");
	halt_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(busy_v && i_halt_mode && permit_q && !i_stop_mode && !t_done) |=> busy_v) else $error("halt stopped");
	// a full write is covered by its completion pulse; the long span would need a counter
	write_c: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) busy_v && t_done && !abort_v);
	abort_c: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) busy_v && !permit_q);
	stop_c: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) busy_v && i_stop_mode);
	irq_c: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) o_nvm_write_done_irq);
endmodule : nbwc_ctrl

/* File: nbwc_host.sv */
// cpu core model issuing byte wide data memory accesses
`timescale 1ns/100ps
module nbwc_host (
	// clock
	input  wire logic        i_ref_clk,
	// bus toward the controller
	output logic [11:0]      o_addr,
	output logic             o_wr,
	output logic             o_rd,
	output logic [7:0]       o_wdata,
	input  wire logic [7:0]  i_rdata
);
	// bus idles low at time zero
	initial begin
		o_addr  = 12'h000;
		o_wr    = 1'b0;
		o_rd    = 1'b0;
		o_wdata = 8'h00;
	end
	// whole byte move, one strobe cycle; released bus shows inverted values, not stale ones
	task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		o_addr  <= a;
		o_wdata <= d;
		o_wr    <= 1'b1;
		@(posedge i_ref_clk);
		o_wr    <= 1'b0;
		o_addr  <= ~a;
		o_wdata <= ~d;
	endtask : bus_wr
	// byte read; data is registered, so it is taken just after the strobe edge
	task automatic bus_rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge i_ref_clk);
		o_addr <= a;
		o_rd   <= 1'b1;
		@(posedge i_ref_clk);
		o_rd   <= 1'b0;
		o_addr <= ~a;
		#1;
		d = i_rdata;
	endtask : bus_rd
endmodule : nbwc_host

/* File: tb_nbwc_ctrl.sv */
// self checking bench for the nonvolatile byte write controller
`timescale 1ns/100ps
`include "nbwc_cfg.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_nbwc_ctrl;
	logic        clk = 1'b0;   // 50 MHz clock
	logic        rst_n = 1'b0; // sync reset, active low
	logic [11:0] addr;         // host address
	logic        wr;           // host write strobe
	logic        rd;           // host read strobe
	logic [7:0]  wdata;        // host write data
	logic [7:0]  rdata;        // controller read data
	logic        stop = 1'b0;  // stop mode level
	logic        halt = 1'b0;  // halt mode level
	logic        irq_en = 1'b0;  // request enable
	logic        irq_ack = 1'b0; // request ack pulse
	logic        irq;      // gated request
	logic        flag;     // sticky request flag
	logic        busy;     // write busy
	logic        rdy;      // gate settled
	logic [7:0]  v;        // last value read
	int          n_fail = 0;
	int          comparisons = 0;
	int          n;        // busy cycle counter
	always #10 clk = ~clk;
	nbwc_host host (.i_ref_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata), .i_rdata(rdata));
	nbwc_ctrl dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wr(wr), .i_rd(rd),
		.i_wdata(wdata), .o_rdata(rdata), .i_stop_mode(stop), .i_halt_mode(halt),
		.i_irq_enable(irq_en), .i_irq_ack(irq_ack), .o_nvm_write_done_irq(irq),
		.o_write_done_request_flag(flag), .o_nvm_write_busy(busy), .o_read_ready(rdy));
	// wait cycles, sampled clear of the edge
	task automatic idle(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : idle
	// reset values and an unmapped read
	task automatic t_reset;
		host.bus_rd(`NBWC_CTRL_ADDR, v);
		`CHK(v, `NBWC_CTRL_RESET)
		host.bus_rd(12'h123, v);
		`CHK(v, 8'h00)
		`CHK(busy, 1'b0)
		$display("test reset done");
	endtask : t_reset
	// whole byte load; busy bit is not writable
	task automatic t_ctrl;
		host.bus_wr(`NBWC_CTRL_ADDR, 8'h5C);
		host.bus_rd(`NBWC_CTRL_ADDR, v);
		`CHK(v, 8'h58)
		$display("test control done");
	endtask : t_ctrl
	// timed write under halt, with a refused second write and a read during it
	task automatic t_write;
		@(posedge clk);
		halt <= 1'b1;
		host.bus_wr(12'h408, 8'h0A);
		idle(1);
		`CHK(busy, 1'b1)
		host.bus_wr(12'h408, 8'h55);
		host.bus_rd(12'h408, v);
		`CHK(v, `NBWC_UNDEF_BYTE)
		host.bus_rd(`NBWC_CTRL_ADDR, v);
		`CHK(v & 8'h04, 8'h04)
		// seven edges have passed since the write was taken, so n counts busy cycles
		n = 7;
		while (busy === 1'b1 && n < 6000) begin
			idle(1);
			n++;
		end
		`CHK(n, `NBWC_TIME_MULT << (`NBWC_EXP_MAX - 5))
		`CHK(busy, 1'b0)
		`CHK(flag, 1'b1)
		`CHK(irq, 1'b0)
		@(posedge clk);
		halt <= 1'b0;
		irq_en <= 1'b1;
		idle(3);
		`CHK(irq, 1'b1)
		@(posedge clk);
		irq_ack <= 1'b1;
		@(posedge clk);
		irq_ack <= 1'b0;
		idle(2);
		`CHK(flag, 1'b0)
		host.bus_wr(`NBWC_CTRL_ADDR, 8'h50);
		host.bus_wr(12'h408, 8'h33);
		idle(2);
		`CHK(busy, 1'b0)
		$display("test write done");
	endtask : t_write
	// permit cleared mid write gives 00, stop mid write gives FF
	task automatic t_abort;
		host.bus_wr(`NBWC_CTRL_ADDR, 8'h58);
		host.bus_wr(12'h40A, 8'h77);
		idle(100);
		host.bus_wr(`NBWC_CTRL_ADDR, 8'h50);
		idle(2);
		`CHK(busy, 1'b0)
		`CHK(flag, 1'b0)
		host.bus_wr(`NBWC_CTRL_ADDR, 8'h58);
		host.bus_wr(12'h40B, 8'h77);
		idle(100);
		@(posedge clk);
		stop <= 1'b1;
		idle(2);
		`CHK(busy, 1'b0)
		@(posedge clk);
		stop <= 1'b0;
		$display("test abort done");
	endtask : t_abort
	// reads need a settled gate; then check every cell written so far
	task automatic t_read;
		host.bus_rd(12'h408, v);
		`CHK(v, 8'h00)
		host.bus_wr(`NBWC_CTRL_ADDR, 8'h80);
		host.bus_rd(12'h408, v);
		`CHK(v, 8'h00)
		idle(`NBWC_GATE_CYCLES + 10);
		`CHK(rdy, 1'b1)
		host.bus_rd(12'h408, v);
		`CHK(v, 8'h0A)
		host.bus_rd(12'h40A, v);
		`CHK(v, 8'h00)
		host.bus_rd(12'h40B, v);
		`CHK(v, `NBWC_UNDEF_BYTE)
		host.bus_wr(`NBWC_CTRL_ADDR, 8'h00);
		$display("test read done");
	endtask : t_read
	// counts and verdict, the single end of the run
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_ctrl();
		t_write();
		t_abort();
		t_read();
		tally_and_finish();
	end
	// watchdog: the tests need about 5600 cycles
	initial begin
		repeat (50000) @(posedge clk);
		n_fail++;
		tally_and_finish();
	end
endmodule : tb_nbwc_ctrl
